// [verilog/dcc_pkg.sv]
// Purpose: Shared constants and types for the dual comparator control block.
// Assumes: 8-bit special-function register space, one system clock.
// Notes: Bit layout is identical for both comparator control registers.
package dcc_pkg;

   // ****************************************
   // Addresses and field positions
   // ****************************************
   localparam logic [7:0] DCC_CMP0_ADDR = 8'h9E; // First control register
   localparam logic [7:0] DCC_CMP1_ADDR = 8'h9F; // Second control register
   localparam logic [7:0] DCC_CTRL_RESET = 8'h00; // Reset value of both
   localparam int DCC_EN_BIT = 7; // Enable
   localparam int DCC_OUT_BIT = 6; // Output state
   localparam int DCC_RISE_BIT = 5; // Rising flag
   localparam int DCC_FALL_BIT = 4; // Falling flag
   localparam int DCC_HYP_HI = 3; // Positive hysteresis field
   localparam int DCC_HYP_LO = 2;
   localparam int DCC_HYN_HI = 1; // Negative hysteresis field
   localparam int DCC_HYN_LO = 0;
   localparam int DCC_NUM_CMP = 2; // Channel count

   // ****************************************
   // Types
   // ****************************************
   // Register access from the processor core
   typedef struct packed {
      logic [7:0] addr; // Special-function address
      logic wr; // Write strobe
      logic rd; // Read strobe
      logic [7:0] wdata; // Write data
   } dcc_sfr_req_t;

   // Settings driven to one analog core
   typedef struct packed {
      logic enable; // Core powered
      logic [1:0] hyst_pos; // Positive hysteresis code
      logic [1:0] hyst_neg; // Negative hysteresis code
   } dcc_core_ctrl_t;

endpackage

// [verilog/dcc_channel.sv]
// Purpose: One comparator channel: synchroniser, edge flags, control bits.
// Assumes: Raw comparator output is asynchronous to ref_clk.
// Notes: Register written only when its own select is high.
`timescale 1ns/10ps
module dcc_channel (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cmp_raw,
   input wire logic sel_wr,
   input wire logic [7:0] wdata,
   output logic [7:0] reg_value,
   output dcc_pkg::dcc_core_ctrl_t core_ctrl,
   output logic cmp_out_gated,
   output logic rise_irq,
   output logic fall_irq
);
   import dcc_pkg::*;

   logic sync1_q; // First synchroniser stage
   logic sync2_q; // Second stage, safe to use
   logic prev_q; // Previous sample for edges
   logic en_q; // Enable bit
   logic rise_q; // Sticky rising flag
   logic fall_q; // Sticky falling flag
   logic [1:0] hyp_q; // Positive hysteresis
   logic [1:0] hyn_q; // Negative hysteresis
   logic rise_evt; // Rising edge seen
   logic fall_evt; // Falling edge seen

   // ****************************************
   // Synchroniser
   // ****************************************
   // Two flops before any logic looks at the analog output
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sync1_q <= 1'h0;
         sync2_q <= 1'h0;
         prev_q <= 1'h0;
      end else begin
         sync1_q <= cmp_raw;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Edges only count while enabled
   assign rise_evt = en_q && sync2_q && !prev_q;
   assign fall_evt = en_q && !sync2_q && prev_q;

   // ****************************************
   // Control and flags
   // ****************************************
   // Control fields, written by software
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         en_q <= DCC_CTRL_RESET[DCC_EN_BIT];
         hyp_q <= DCC_CTRL_RESET[DCC_HYP_HI:DCC_HYP_LO];
         hyn_q <= DCC_CTRL_RESET[DCC_HYN_HI:DCC_HYN_LO];
      end else if (sel_wr) begin
         en_q <= wdata[DCC_EN_BIT];
         hyp_q <= wdata[DCC_HYP_HI:DCC_HYP_LO];
         hyn_q <= wdata[DCC_HYN_HI:DCC_HYN_LO];
      end
   end

   // Sticky flags: hardware event wins over a software write
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rise_q <= DCC_CTRL_RESET[DCC_RISE_BIT];
         fall_q <= DCC_CTRL_RESET[DCC_FALL_BIT];
      end else begin
         if (rise_evt) begin
            rise_q <= 1'h1;
         end else if (sel_wr) begin
            rise_q <= wdata[DCC_RISE_BIT];
         end
         if (fall_evt) begin
            fall_q <= 1'h1;
         end else if (sel_wr) begin
            fall_q <= wdata[DCC_FALL_BIT];
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Read view; output bit is the live synchronised state
   assign reg_value = {en_q, sync2_q, rise_q, fall_q, hyp_q, hyn_q};
   assign core_ctrl.enable = en_q;
   assign core_ctrl.hyst_pos = hyp_q;
   assign core_ctrl.hyst_neg = hyn_q;
   // Pin output forced low while disabled
   assign cmp_out_gated = en_q & sync2_q;
   // Interrupt requests follow the flags, suspended while off
   assign rise_irq = en_q & rise_q;
   assign fall_irq = en_q & fall_q;

endmodule // dcc_channel

// [verilog/dcc_top.sv]
// Purpose: Two-channel comparator control with special-function registers.
// Assumes: Core issues single-cycle rd/wr strobes on ref_clk.
// Notes: Read data registered, valid the cycle after rd.
`timescale 1ns/10ps
module dcc_top (
   input wire logic ref_clk,
   input wire logic rst_b,
   input dcc_pkg::dcc_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic [1:0] cmp_raw,
   input wire logic [1:0] pin_push_pull,
   input wire logic cmp0_reset_select,
   output dcc_pkg::dcc_core_ctrl_t [1:0] core_ctrl,
   output logic [1:0] cmp_pin_out,
   output logic [1:0] cmp_pin_oe,
   output logic [1:0] cmp_irq_req,
   output logic cmp0_reset_req
);
   import dcc_pkg::*;

   logic [1:0] sel_wr; // Per-channel write select
   logic [7:0] reg_value [DCC_NUM_CMP]; // Per-channel read view
   logic [1:0] gated; // Gated comparator outputs
   logic [1:0] rise_irq; // Rise requests
   logic [1:0] fall_irq; // Fall requests
   logic [7:0] rdata_d; // Next read data
   logic hit_d; // Address decodes
   logic [7:0] rdata_q; // Registered read data
   logic hit_q; // Registered hit
   logic [1:0] pin_out_q; // Registered pin data
   logic [1:0] pin_oe_q; // Registered pin enable
   logic [1:0] irq_q; // Registered interrupt requests
   logic rst_req_q; // Registered reset request

   // ****************************************
   // Address decode
   // ****************************************
   // Each register at its own address
   always_comb begin
      sel_wr = 2'h0;
      if (sfr_req.wr && sfr_req.addr == DCC_CMP0_ADDR) begin
         sel_wr[0] = 1'h1;
      end else if (sfr_req.wr && sfr_req.addr == DCC_CMP1_ADDR) begin
         sel_wr[1] = 1'h1;
      end
   end

   // Read mux; unmapped addresses read zero without a hit
   always_comb begin
      rdata_d = 8'h00;
      hit_d = 1'h0;
      if (sfr_req.addr == DCC_CMP0_ADDR) begin
         rdata_d = reg_value[0];
         hit_d = 1'h1;
      end else if (sfr_req.addr == DCC_CMP1_ADDR) begin
         rdata_d = reg_value[1];
         hit_d = 1'h1;
      end
   end

   // ****************************************
   // Channels
   // ****************************************
   // Two identical channels
   for (genvar i = 0; i < DCC_NUM_CMP; i++) begin : g_ch
      dcc_channel u_ch (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .cmp_raw(cmp_raw[i]),
         .sel_wr(sel_wr[i]),
         .wdata(sfr_req.wdata),
         .reg_value(reg_value[i]),
         .core_ctrl(core_ctrl[i]),
         .cmp_out_gated(gated[i]),
         .rise_irq(rise_irq[i]),
         .fall_irq(fall_irq[i])
      );
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   // Read data captured on rd
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
         hit_q <= 1'h0;
      end else if (sfr_req.rd) begin
         rdata_q <= rdata_d;
         hit_q <= hit_d;
      end else begin
         hit_q <= 1'h0;
      end
   end

   // Pin driver: push-pull drives both levels, open drain only low
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pin_out_q <= 2'h0;
         pin_oe_q <= 2'h0;
      end else begin
         pin_out_q <= gated;
         pin_oe_q <= pin_push_pull | ~gated;
      end
   end

   // Interrupt requests: rise, fall, or both flags
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irq_q <= 2'h0;
      end else begin
         irq_q <= rise_irq | fall_irq;
      end
   end

   // Reset request from the first channel only; a low output qualifies
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rst_req_q <= 1'h0;
      end else begin
         rst_req_q <= cmp0_reset_select & core_ctrl[0].enable & ~reg_value[0][DCC_OUT_BIT];
      end
   end

   assign sfr_rdata = rdata_q;
   assign sfr_hit = hit_q;
   assign cmp_pin_out = pin_out_q;
   assign cmp_pin_oe = pin_oe_q;
   assign cmp_irq_req = irq_q;
   assign cmp0_reset_req = rst_req_q;

endmodule // dcc_top

// [sim/dcc_properties.sv]
// Purpose: Port-level properties of the comparator control block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to dcc_top from the bench top file.
`timescale 1ns/10ps
module dcc_properties (
   input wire logic ref_clk,
   input wire logic rst_b,
   input dcc_pkg::dcc_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   input wire logic [1:0] cmp_raw,
   input wire logic cmp0_reset_select,
   input dcc_pkg::dcc_core_ctrl_t [1:0] core_ctrl,
   input wire logic [1:0] cmp_pin_out,
   input wire logic [1:0] cmp_irq_req,
   input wire logic cmp0_reset_req
);
   import dcc_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic rd_map; // Read aimed at either control register
   assign rd_map = sfr_req.rd && (sfr_req.addr == DCC_CMP0_ADDR || sfr_req.addr == DCC_CMP1_ADDR);
   // ****************************************
   // Assertions
   // ****************************************
   AST_PIN_LOW: assert property (!core_ctrl[0].enable |=> !cmp_pin_out[0])
      else $error("pin driven while off");
   AST_IRQ_OFF: assert property (!core_ctrl[1].enable |=> !cmp_irq_req[1])
      else $error("irq while off");
   AST_HIT: assert property (rd_map |=> sfr_hit)
      else $error("mapped read without hit");
   AST_MISS: assert property (sfr_req.rd && !rd_map |=> !sfr_hit && sfr_rdata == 8'h00)
      else $error("unmapped read answered");
   AST_WR_CH1: assert property (sfr_req.wr && sfr_req.addr == DCC_CMP1_ADDR
      |=> core_ctrl[1] == {$past(sfr_req.wdata[7]), $past(sfr_req.wdata[3:0])}) else $error("write not applied");
   AST_RD_CH0: assert property (sfr_req.rd && sfr_req.addr == DCC_CMP0_ADDR
      |=> {sfr_rdata[7], sfr_rdata[3:0]} == $past(core_ctrl[0])) else $error("read data wrong");
   AST_RISE_IRQ: assert property ($rose(cmp_raw[0]) && core_ctrl[0].enable ##1 core_ctrl[0].enable[*4]
      |-> cmp_irq_req[0]) else $error("rise gave no irq");
   AST_RST_SEL: assert property (!cmp0_reset_select |=> !cmp0_reset_req)
      else $error("reset request unselected");
   AST_RST_EN: assert property (!core_ctrl[0].enable |=> !cmp0_reset_req)
      else $error("reset request while off");
   // Main scenarios reached
   cover property (rd_map ##1 sfr_hit);
   cover property (cmp_irq_req[0]);
   cover property (cmp0_reset_req);
endmodule // dcc_properties

// [sim/dcc_core_model.sv]
// Purpose: Behavioural pair of analog comparator cores.
// Assumes: level_in is the wanted plus-above-minus result.
// Notes: Slow mode delays the answer by four clocks.
`timescale 1ns/10ps
module dcc_core_model (
   input wire logic ref_clk,
   input dcc_pkg::dcc_core_ctrl_t [1:0] core_ctrl,
   input wire logic [1:0] level_in,
   input wire logic [1:0] slow,
   output logic [1:0] cmp_raw
);
   import dcc_pkg::*;
   logic [3:0] dly_q [2]; // Settling delay line per core
   // Delay line models a slow core
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 2; i++) dly_q[i] <= {dly_q[i][2:0], level_in[i]};
   end
   // Shut-down core reads low, live core gives 1 for plus above minus
   always_comb begin
      for (int i = 0; i < 2; i++) cmp_raw[i] = core_ctrl[i].enable && (slow[i] ? dly_q[i][3] : level_in[i]);
   end
endmodule // dcc_core_model

// [sim/dual_comparator_control_bench.sv]
// Purpose: Self-checking bench for the dual comparator control block.
// Assumes: Core model drives cmp_raw; second core is slow.
// Notes: One task per scenario; counts printed before the verdict.
`timescale 1ns/10ps
module dual_comparator_control_bench;
   import dcc_pkg::*;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   dcc_sfr_req_t req = '0; // Register request
   logic [7:0] sfr_rdata;
   logic sfr_hit, sel0 = 1'h0, rst_req;
   logic [1:0] cmp_raw, pin_out, pin_oe, irq, lvl = 2'h0, pp = 2'h3;
   dcc_core_ctrl_t [1:0] cc;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   dcc_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .cmp_raw(cmp_raw), .pin_push_pull(pp), .cmp0_reset_select(sel0), .core_ctrl(cc), .cmp_pin_out(pin_out),
      .cmp_pin_oe(pin_oe), .cmp_irq_req(irq), .cmp0_reset_req(rst_req));
   dcc_core_model model_u (.ref_clk(ref_clk), .core_ctrl(cc), .level_in(lvl), .slow(2'h2), .cmp_raw(cmp_raw));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'h1;
      @(posedge ref_clk);
      req.wr <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      req.addr <= a;
      req.rd <= 1'h1;
      @(posedge ref_clk);
      req.rd <= 1'h0;
      @(negedge ref_clk);
      chk("read data", sfr_rdata, exp);
      chk("read hit", {7'h00, sfr_hit}, {7'h00, a == DCC_CMP0_ADDR || a == DCC_CMP1_ADDR});
   endtask
   task automatic settle;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic flip(input int ch);
      @(posedge ref_clk);
      lvl <= lvl ^ 2'(1 << ch);
      settle();
   endtask
   task automatic t_reset;
      rchk(DCC_CMP0_ADDR, DCC_CTRL_RESET);
      rchk(DCC_CMP1_ADDR, DCC_CTRL_RESET);
      rchk(8'hA0, 8'h00);
      chk("reset outputs", {3'h0, irq, pin_out, rst_req}, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_hyst;
      logic [7:0] a;
      for (int ch = 0; ch < 2; ch++) begin
         for (int c = 0; c < 4; c++) begin
            a = DCC_CMP0_ADDR + 8'(ch);
            wr(a, {4'h4, 2'(c), 2'(3 - c)});
            @(negedge ref_clk);
            chk("core settings", {3'h0, cc[ch]}, {4'h0, 2'(c), 2'(3 - c)});
            rchk(a, {4'h0, 2'(c), 2'(3 - c)});
         end
      end
      $display("hysteresis test done");
   endtask
   task automatic t_edge(input int ch);
      logic [7:0] a;
      a = DCC_CMP0_ADDR + 8'(ch);
      wr(a, 8'h80);
      flip(ch);
      rchk(a, 8'hE0);
      chk("irq and pin", {5'h0, irq[ch], pin_oe[ch], pin_out[ch]}, 8'h07);
      settle();
      rchk(a, 8'hE0);
      wr(a, 8'h80);
      rchk(a, 8'hC0);
      chk("irq cleared", {7'h0, irq[ch]}, 8'h00);
      flip(ch);
      rchk(a, 8'h90);
      flip(ch);
      rchk(a, 8'hF0);
      wr(a, 8'h00);
      settle();
      rchk(a, 8'h00);
      chk("off outputs", {6'h0, irq[ch], pin_out[ch]}, 8'h00);
      flip(ch);
      $display("edge test done");
   endtask
   task automatic t_rst;
      wr(DCC_CMP1_ADDR, 8'h80);
      sel0 <= 1'h1;
      settle();
      chk("reset from second", {7'h0, rst_req}, 8'h00);
      wr(DCC_CMP0_ADDR, 8'h80);
      pp <= 2'h0;
      settle();
      chk("reset from first", {7'h0, rst_req}, 8'h01);
      chk("open drain low", {6'h0, pin_oe[0], pin_out[0]}, 8'h02);
      flip(0);
      chk("open drain high", {6'h0, pin_oe[0], pin_out[0]}, 8'h01);
      chk("reset on high", {7'h0, rst_req}, 8'h00);
      $display("reset source test done");
   endtask
   // Falling edge lands on the very edge that a clearing write is taken
   task automatic t_collide;
      wr(DCC_CMP0_ADDR, 8'h80);
      @(posedge ref_clk);
      lvl <= lvl ^ 2'h1;
      @(posedge ref_clk);
      wr(DCC_CMP0_ADDR, 8'h80);
      rchk(DCC_CMP0_ADDR, 8'h90);
      $display("set over clear test done");
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_reset();
      t_hyst();
      t_edge(0);
      t_edge(1);
      t_rst();
      t_collide();
      close_out();
   end
   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_errors++;
         close_out();
      end
   end
endmodule // dual_comparator_control_bench
bind dcc_top dcc_properties props_u (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .sfr_hit(sfr_hit), .cmp_raw(cmp_raw), .cmp0_reset_select(cmp0_reset_select), .core_ctrl(core_ctrl),
   .cmp_pin_out(cmp_pin_out), .cmp_irq_req(cmp_irq_req), .cmp0_reset_req(cmp0_reset_req));
